// File: src/tts_source.sv
// Transmit transport test source: pattern, sine and latency marker
`timescale 1ns/1ps
module tts_source
	import tts_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [1:0] source_sel,
	input wire logic [1:0] octets_per_frame,
	input wire logic scramble_en,
	input wire logic sysref,
	input wire logic [LMF_CNT_W-1:0] frames_per_lmf,
	input wire logic link_error,
	input wire logic link_accept,
	output logic [WORD_W-1:0] link_data,
	output logic link_valid,
	output logic sample_in_valid,
	output logic sample_in_accept,
	output logic latency_marker,
	output logic lmf_boundary,
	output logic link_error_irq
);
	tts_state_t state, next_state;
	logic [LMF_CNT_W-1:0] lmf_cnt, next_lmf_cnt;
	logic [3:0] phase, next_phase;
	logic [14:0] scr, next_scr;
	logic [WORD_W-1:0] word, next_word;
	logic wvalid, next_wvalid;
	logic marker, next_marker;
	logic irq, next_irq;
	logic bound, next_bound;
	logic samp_acc, next_samp_acc;
	logic [WORD_W-1:0] raw, scr_word;
	logic [WORD_W-1:0] buf_data;
	logic buf_in_ready, buf_valid;
	logic [SAMPLE_W-1:0] sine_s;
	logic [14:0] s;
	logic fire;

	// Sine table of 16 steps, two's complement
	function automatic logic [15:0] sine_lut(input logic [3:0] i);
		case (i)
			4'h0: sine_lut = 16'h0000;
			4'h1: sine_lut = 16'h30FB;
			4'h2: sine_lut = 16'h5A82;
			4'h3: sine_lut = 16'h7641;
			4'h4: sine_lut = 16'h7FFF;
			4'h5: sine_lut = 16'h7641;
			4'h6: sine_lut = 16'h5A82;
			4'h7: sine_lut = 16'h30FB;
			4'h8: sine_lut = 16'h0000;
			4'h9: sine_lut = 16'hCF05;
			4'hA: sine_lut = 16'hA57E;
			4'hB: sine_lut = 16'h89BF;
			4'hC: sine_lut = 16'h8001;
			4'hD: sine_lut = 16'h89BF;
			4'hE: sine_lut = 16'hA57E;
			default: sine_lut = 16'hCF05;
		endcase
	endfunction

	// A frame is produced only when the buffer can take it
	// A word already in flight must also find room, or it would be lost
	assign fire = (state != TTS_IDLE) && buf_in_ready &&
		(!wvalid || link_accept);

	always_comb begin
		sine_s = sine_lut(phase);
		raw = '0;
		case (source_sel)
			SRC_PATTERN: begin
				// One frame of pattern, laid out by frame size
				case (octets_per_frame)
					OPF_1: raw = {56'h0, SHORT_PAT[63:56]};
					OPF_2: raw = {48'h0, SHORT_PAT[63:48]};
					OPF_4: raw = {32'h0, SHORT_PAT[63:32]};
					default: raw = SHORT_PAT;
				endcase
			end
			SRC_SINE: raw = {4{sine_s}};
			SRC_LATENCY: begin
				if (state == TTS_RUN) begin
					raw = {48'h0, LAT_SAMPLE};
				end
			end
			default: raw = '0;
		endcase
		// Self-synchronous scrambler, one bit per step, msb first
		s = scr;
		scr_word = raw;
		for (int b = WORD_W - 1; b >= 0; b--) begin
			scr_word[b] = raw[b] ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
			s = {s[13:0], scr_word[b]};
		end
	end

	always_comb begin
		next_state = state;
		next_lmf_cnt = lmf_cnt;
		next_phase = phase;
		next_scr = scr;
		next_word = word;
		next_wvalid = 1'b0;
		next_marker = 1'b0;
		next_bound = 1'b0;
		next_samp_acc = buf_in_ready;
		next_irq = link_error;
		// Multiframe counter, restarted by every sysref
		if (sysref) begin
			next_lmf_cnt = '0;
			next_bound = 1'b1;
		end else if (lmf_cnt >= frames_per_lmf - 8'h01) begin
			next_lmf_cnt = '0;
			next_bound = 1'b1;
		end else begin
			next_lmf_cnt = 8'(lmf_cnt + 8'h01);
		end
		case (state)
			TTS_IDLE: begin
				if (enable) begin
					next_state = TTS_RUN;
				end
			end
			TTS_RUN: begin
				if (!enable) begin
					next_state = TTS_IDLE;
				end else if (fire) begin
					next_wvalid = 1'b1;
					next_word = scramble_en ? scr_word : raw;
					if (scramble_en) begin
						next_scr = s;
					end
					next_phase = 4'(phase + 4'h1);
					if (source_sel == SRC_LATENCY) begin
						next_marker = LAT_SAMPLE[LAT_MSB];
						next_state = TTS_LAT_DONE;
					end
				end
			end
			TTS_LAT_DONE: begin
				if (fire) begin
					next_wvalid = 1'b1;
					next_word = scramble_en ? scr_word : raw;
					if (scramble_en) begin
						next_scr = s;
					end
				end
				if (!enable) begin
					next_state = TTS_IDLE;
				end
			end
			default: next_state = TTS_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= TTS_IDLE;
			lmf_cnt <= '0;
			phase <= 4'h0;
			scr <= SCR_SEED;
			word <= '0;
			wvalid <= 1'b0;
			marker <= 1'b0;
			irq <= 1'b0;
			bound <= 1'b0;
			samp_acc <= 1'b0;
		end else begin
			state <= next_state;
			lmf_cnt <= next_lmf_cnt;
			phase <= next_phase;
			scr <= next_scr;
			word <= next_word;
			wvalid <= next_wvalid;
			marker <= next_marker;
			irq <= next_irq;
			bound <= next_bound;
			samp_acc <= next_samp_acc;
		end
	end

	// One frame word per frame clock, passed whole to the link side
	tts_buf u_buf (
		.clock(clock),
		.rst_n(rst_n),
		.in_data(word),
		.in_valid(wvalid),
		.in_ready(buf_in_ready),
		.out_data(buf_data),
		.out_valid(buf_valid),
		.out_ready(link_accept)
	);

	assign link_data = buf_data;
	assign link_valid = buf_valid;
	assign sample_in_valid = wvalid;
	assign sample_in_accept = samp_acc;
	assign latency_marker = marker;
	assign lmf_boundary = bound;
	assign link_error_irq = irq;
endmodule // tts_source

// File: src/tts_pkg.sv
// Constants and types for the transmit transport test source
// What this block does
// - Short test pattern lasts one frame, repeated back to back without gaps.
// - Pattern layout follows octets-per-frame 1, 2, 4 or 8; receiver checks same.
// - A sine wave source is offered as alternative payload.
// - Optional scrambling; receiver descrambles and still recovers the pattern.
// - Each SYSREF restarts the local multiframe counter.
// - Latency test mode injects one 16-bit sample of 8000h.
// - The injected sample's top bit is also driven to a marker pin.
// - In one-lane, four-converter, eight-octet setup link clock is twice frame; here one clock, whole 64-bit word per cycle.
package tts_pkg;
	localparam int SAMPLE_W = 16;
	localparam int OCT_W = 8;
	localparam int FRAME_OCT = 8;
	localparam int WORD_W = FRAME_OCT * OCT_W;
	localparam logic [63:0] SHORT_PAT = 64'hF1E2D3C4B5A69780;
	localparam logic [15:0] LAT_SAMPLE = 16'h8000;
	localparam int LAT_MSB = 15;
	localparam int LMF_CNT_W = 8;
	localparam logic [7:0] LMF_FRAMES_DEF = 8'h20;
	localparam int SINE_STEPS = 16;
	localparam logic [14:0] SCR_SEED = 15'h7FFF;
	localparam int SCR_TAP_A = 14;
	localparam int SCR_TAP_B = 13;
	localparam int BUF_DEPTH = 2;
	localparam logic [1:0] OPF_1 = 2'h0;
	localparam logic [1:0] OPF_2 = 2'h1;
	localparam logic [1:0] OPF_4 = 2'h2;
	localparam logic [1:0] OPF_8 = 2'h3;
	localparam logic [1:0] SRC_PATTERN = 2'h0;
	localparam logic [1:0] SRC_SINE = 2'h1;
	localparam logic [1:0] SRC_LATENCY = 2'h2;
	typedef enum logic [1:0] {TTS_IDLE, TTS_RUN, TTS_LAT_DONE} tts_state_t;
endpackage

// File: src/tts_buf.sv
// Two-entry valid/ready buffer for frame words
`timescale 1ns/1ps
module tts_buf
	import tts_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WORD_W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WORD_W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [WORD_W-1:0] mem [BUF_DEPTH];
	logic [WORD_W-1:0] next_mem [BUF_DEPTH];
	logic wp, rp, next_wp, next_rp;
	logic [1:0] cnt, next_cnt;
	logic push, pop;

	always_comb begin
		push = in_valid && (cnt != 2'h2);
		pop = (cnt != 2'h0) && out_ready;
		next_mem = mem;
		next_wp = wp;
		next_rp = rp;
		next_cnt = cnt;
		if (push) begin
			next_mem[wp] = in_data;
			next_wp = ~wp;
		end
		if (pop) begin
			next_rp = ~rp;
		end
		next_cnt = 2'(cnt + {1'b0, push} - {1'b0, pop});
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
		end
		mem <= next_mem;
	end

	// Handshake flags and read word come straight from flops
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			in_ready <= (next_cnt != 2'h2);
			out_valid <= (next_cnt != 2'h0);
		end
		out_data <= next_mem[next_rp];
	end
endmodule // tts_buf

// File: verification/tts_source_assertions.sv
// Property checker for the test source ports
`timescale 1ns/1ps
module tts_source_assertions
	import tts_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [1:0] source_sel,
	input wire logic sysref,
	input wire logic [LMF_CNT_W-1:0] frames_per_lmf,
	input wire logic link_error,
	input wire logic link_accept,
	input wire logic [WORD_W-1:0] link_data,
	input wire logic link_valid,
	input wire logic sample_in_valid,
	input wire logic sample_in_accept,
	input wire logic latency_marker,
	input wire logic lmf_boundary,
	input wire logic link_error_irq
);
	logic [LMF_CNT_W:0] gap;
	always_ff @(posedge clock) begin
		if (!rst_n || !enable || sysref || lmf_boundary) gap <= '0;
		else gap <= gap + 1'b1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	irq_cause_a: assert property ($rose(link_error_irq) |->
		$past(link_error)) else $error("irq without error");
	irq_clear_a: assert property (!link_error |=>
		!link_error_irq) else $error("irq stuck");
	marker_valid_a: assert property (latency_marker |->
		sample_in_valid && source_sel == SRC_LATENCY) else $error("marker");
	marker_once_a: assert property (latency_marker |=>
		!latency_marker [*4]) else $error("marker repeats");
	lat_word_a: assert property (latency_marker |-> ##[1:20]
		(link_valid && link_data[15:0] == LAT_SAMPLE)) else $error("lat");
	stall_hold_a: assert property (link_valid && !link_accept |=>
		link_valid && $stable(link_data)) else $error("word lost");
	word_accept_a: assert property (sample_in_valid |->
		sample_in_accept) else $error("valid without accept");
	pattern_flow_a: assert property ((enable && link_accept &&
		source_sel == SRC_PATTERN) [*4] |=> sample_in_valid)
		else $error("frame gap");
	lmf_period_a: assert property (gap <= frames_per_lmf + 1'b1)
		else $error("boundary late");
endmodule // tts_source_assertions

bind tts_source tts_source_assertions chk_u (.clock, .rst_n, .enable,
	.source_sel, .sysref, .frames_per_lmf, .link_error, .link_accept,
	.link_data, .link_valid, .sample_in_valid, .sample_in_accept,
	.latency_marker, .lmf_boundary, .link_error_irq);

// File: verification/tts_link_model.sv
// Link receiver model: accepts and descrambles words
`timescale 1ns/1ps
module tts_link_model
	import tts_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic descr,
	input wire logic [WORD_W-1:0] link_data,
	input wire logic link_valid,
	output logic link_accept,
	output logic [WORD_W-1:0] word,
	output logic got
);
	logic [14:0] h = SCR_SEED;
	logic [14:0] t;
	logic [WORD_W-1:0] w;
	always @(posedge clock) begin
		got <= 1'b0;
		link_accept <= rst_n && !stall;
		if (link_valid && link_accept) begin
			t = h;
			for (int i = WORD_W - 1; i >= 0; i--) begin
				w[i] = link_data[i] ^ (descr & (t[13] ^ t[14]));
				t = {t[13:0], link_data[i]};
			end
			if (descr) h <= t;
			word <= w;
			got <= 1'b1;
		end
	end
endmodule // tts_link_model

// File: verification/tb_tts_source.sv
// Testbench for the transport test source
`timescale 1ns/1ps
module tb_tts_source;
	import tts_pkg::*;
	logic clock = 0, rst_n = 0, enable = 0, scramble_en = 0, sysref = 0;
	logic link_error = 0, stall = 0;
	logic [1:0] source_sel = SRC_PATTERN, octets_per_frame = OPF_8;
	logic [LMF_CNT_W-1:0] frames_per_lmf = 8'h08;
	logic [WORD_W-1:0] link_data, word;
	logic link_accept, link_valid, sample_in_valid, sample_in_accept;
	logic latency_marker, lmf_boundary, link_error_irq, got;
	int errors = 0, samples_checked = 0, cycles = 0;
	tts_source dut_u (.clock, .rst_n, .enable, .source_sel,
		.octets_per_frame, .scramble_en, .sysref, .frames_per_lmf,
		.link_error, .link_accept, .link_data, .link_valid,
		.sample_in_valid, .sample_in_accept, .latency_marker,
		.lmf_boundary, .link_error_irq);
	tts_link_model rx_u (.clock, .rst_n, .stall, .descr(scramble_en),
		.link_data, .link_valid, .link_accept, .word, .got);
	initial forever #2 clock = ~clock;
	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task results;
		if (errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			chk("timeout", 0, 1);
			results;
		end
	end
	task t_pat;
		int n;
		logic [63:0] e;
		for (int s = 0; s < 2; s++) for (int f = 0; f < 4; f++) begin
			scramble_en = s[0];
			octets_per_frame = f[1:0];
			enable = 1;
			e = SHORT_PAT >> (64 - (8 << f));
			step(8);
			n = 0;
			repeat (8) begin
				if (got) chk("pattern", e, word);
				n += got;
				step(1);
			end
			chk("frames", 8, n);
			chk("accept", 1, sample_in_accept);
			chk("irq", 0, link_error_irq);
			enable = 0;
			step(4);
		end
		scramble_en = 0;
	endtask
	task t_stall;
		int n;
		stall = 1;
		enable = 1;
		step(8);
		n = 0;
		repeat (4) begin
			n += sample_in_valid;
			step(1);
		end
		chk("full", 0, n);
		chk("held", 1, link_valid);
		enable = 0;
		stall = 0;
		step(8);
		chk("drained", 0, link_valid);
	endtask
	task t_sine;
		logic [63:0] p;
		int d;
		source_sel = SRC_SINE;
		enable = 1;
		step(6);
		d = 0;
		p = word;
		repeat (16) begin
			if (got) chk("sine", {4{word[15:0]}}, word);
			if (got) d += (word !== p);
			p = word;
			step(1);
		end
		chk("tone", 1, d > 4);
		enable = 0;
		step(6);
	endtask
	task t_lat;
		int n, m;
		source_sel = SRC_LATENCY;
		enable = 1;
		n = 0;
		m = 0;
		repeat (12) begin
			n += latency_marker;
			if (got && m++ == 0) begin
				chk("latency", {48'h0, LAT_SAMPLE}, word);
				chk("neg", 1, $signed(word[15:0]) == -32768);
			end
			step(1);
		end
		chk("marker", 1, n);
		enable = 0;
		step(6);
	endtask
	task t_sync;
		int d[3];
		source_sel = SRC_PATTERN;
		enable = 1;
		for (int i = 0; i < 3; i++) begin
			sysref = 1;
			step(1);
			sysref = 0;
			step(1);
			d[i] = 1;
			while (!lmf_boundary && d[i] < 40) begin
				d[i]++;
				step(1);
			end
			chk("realign", frames_per_lmf, d[i]);
			step(2 * frames_per_lmf - 1 - d[i]);
		end
		link_error = 1;
		step(2);
		chk("irq set", 1, link_error_irq);
		link_error = 0;
		step(2);
		chk("irq clear", 0, link_error_irq);
		enable = 0;
	endtask
	initial begin
		step(6);
		rst_n = 1;
		step(1);
		t_pat;
		t_stall;
		t_sine;
		t_lat;
		t_sync;
		results;
	end
endmodule // tb_tts_source
